// file: psi_defs.vh
`ifndef PSI_DEFS_VH
`define PSI_DEFS_VH

// ----------------------------------------------------------------
// Register addresses on the management interface
// ----------------------------------------------------------------
`define PSI_ADDR_BASIC_STATUS 5'h01
`define PSI_ADDR_SUMMARY 5'h10
`define PSI_ADDR_INT_CTRL 5'h11
`define PSI_ADDR_EVENT_STATUS 5'h12

// ----------------------------------------------------------------
// Summary status field positions
// ----------------------------------------------------------------
`define PSI_SUM_IRQ 7
`define PSI_SUM_RFAULT 6
`define PSI_SUM_JABBER 5
`define PSI_SUM_ANC 4
`define PSI_SUM_LOOP 3
`define PSI_SUM_DUPLEX 2
`define PSI_SUM_SPEED10 1
`define PSI_SUM_LINK 0
`define PSI_SUM_UPPER 8'h00

// ----------------------------------------------------------------
// Interrupt control fields and reset values
// ----------------------------------------------------------------
`define PSI_ICR_TEST_FORCE 2
`define PSI_ICR_EVENT_EN 1
`define PSI_ICR_OE 0
`define PSI_ICR_RESERVED 13'h0000
`define PSI_ICR_RESET 3'h0

// ----------------------------------------------------------------
// Event status register: flags in the upper byte, enables below
// ----------------------------------------------------------------
`define PSI_EVT_FLAG_MSB 15
`define PSI_EVT_FLAG_LSB 8
`define PSI_EVT_EN_MSB 7
`define PSI_EVT_RESET 8'h00

// ----------------------------------------------------------------
// Serial management frame constants
// ----------------------------------------------------------------
`define PSI_PRE_LEN 6'd32
`define PSI_HDR_LAST 6'd12
`define PSI_DATA_LAST 6'd15
`define PSI_OP_READ 2'h2
`define PSI_OP_WRITE 2'h1

`endif

// file: psi_mgmt_serial.v
`timescale 1ns/100ps
`default_nettype none
`include "psi_defs.vh"

// Serial management slave: decodes frames clocked by the station's
// management clock and turns them into register strobes on CLK.
module psi_mgmt_serial #(
   parameter [4:0] PHY_ADDR = 5'h01
) (
   input wire clk,
   input wire rst,
   input wire mdc_pin,
   input wire mdio_pin,
   output reg mdio_o,
   output reg mdio_oe,
   output reg rd_stb,
   output reg wr_stb,
   output reg [4:0] reg_addr,
   output reg [15:0] wr_data,
   input wire [15:0] rd_data
);

   // ----------------------------------------------------------------
   // Frame states
   // ----------------------------------------------------------------
   localparam [1:0] S_PRE = 2'h0;  // Counting preamble ones.
   localparam [1:0] S_HDR = 2'h1;  // Collecting start, opcode and addresses.
   localparam [1:0] S_TA = 2'h2;   // Turnaround.
   localparam [1:0] S_DATA = 2'h3; // Sixteen data bits.

   reg mdc_s1, mdc_s2, mdc_d;  // Clock pin synchroniser and edge history.
   reg mdio_s1, mdio_s2;       // Data pin synchroniser.
   reg [1:0] state;            // Current frame phase.
   reg [5:0] cnt;              // Bit counter within a phase.
   reg [15:0] shift;           // Shared shift register for both directions.
   reg is_read;                // Frame in progress is a read.
   wire mdc_rise;              // Rising edge of the management clock.
   wire bit_in;                // Sampled data bit.
   wire [12:0] hdr;            // Header as it stands after its last bit.

   assign mdc_rise = mdc_s2 & ~mdc_d;
   assign bit_in = mdio_s2;
   assign hdr = {shift[11:0], bit_in};

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Both pins pass the same depth so that a bit lines up with its edge.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         mdc_s1 <= 1'b0;
         mdc_s2 <= 1'b0;
         mdc_d <= 1'b0;
         mdio_s1 <= 1'b1;
         mdio_s2 <= 1'b1;
      end else begin
         mdc_s1 <= mdc_pin;
         mdc_s2 <= mdc_s1;
         mdc_d <= mdc_s2;
         mdio_s1 <= mdio_pin;
         mdio_s2 <= mdio_s1;
      end
   end

   // ----------------------------------------------------------------
   // Frame sequencer
   // ----------------------------------------------------------------
   // The device changes its driven bit just after a rising edge, so the
   // station sees it stable at the following rising edge.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= S_PRE;
         cnt <= 6'd0;
         shift <= 16'h0000;
         is_read <= 1'b0;
         mdio_o <= 1'b1;
         mdio_oe <= 1'b0;
         rd_stb <= 1'b0;
         wr_stb <= 1'b0;
         reg_addr <= 5'h00;
         wr_data <= 16'h0000;
      end else begin
         rd_stb <= 1'b0;
         wr_stb <= 1'b0;
         if (rd_stb) begin
            // Capture in the strobe cycle, before any clear-on-read lands.
            shift <= rd_data;
         end else if (mdc_rise) begin
            case (state)
               S_PRE: begin
                  if (bit_in) begin
                     if (cnt != `PSI_PRE_LEN) begin
                        cnt <= cnt + 6'd1;
                     end
                  end else if (cnt == `PSI_PRE_LEN) begin
                     // First start bit seen after a full preamble.
                     state <= S_HDR;
                     cnt <= 6'd0;
                     shift <= 16'h0000;
                  end else begin
                     cnt <= 6'd0;
                  end
               end
               S_HDR: begin
                  shift <= {shift[14:0], bit_in};
                  cnt <= cnt + 6'd1;
                  if (cnt == `PSI_HDR_LAST) begin
                     cnt <= 6'd0;
                     if (hdr[12] && hdr[9:5] == PHY_ADDR &&
                         (hdr[11:10] == `PSI_OP_READ || hdr[11:10] == `PSI_OP_WRITE)) begin
                        state <= S_TA;
                        reg_addr <= hdr[4:0];
                        is_read <= (hdr[11:10] == `PSI_OP_READ);
                        rd_stb <= (hdr[11:10] == `PSI_OP_READ);
                     end else begin
                        // Frames for another address are ignored whole.
                        state <= S_PRE;
                     end
                  end
               end
               S_TA: begin
                  cnt <= cnt + 6'd1;
                  if (cnt == 6'd0) begin
                     if (is_read) begin
                        mdio_oe <= 1'b1;
                        mdio_o <= 1'b0;
                     end
                  end else begin
                     state <= S_DATA;
                     cnt <= 6'd0;
                     if (is_read) begin
                        mdio_o <= shift[15];
                        shift <= {shift[14:0], 1'b0};
                     end
                  end
               end
               S_DATA: begin
                  cnt <= cnt + 6'd1;
                  if (is_read) begin
                     if (cnt == `PSI_DATA_LAST) begin
                        mdio_oe <= 1'b0;
                        mdio_o <= 1'b1;
                        state <= S_PRE;
                        cnt <= 6'd0;
                     end else begin
                        mdio_o <= shift[15];
                        shift <= {shift[14:0], 1'b0};
                     end
                  end else begin
                     shift <= {shift[14:0], bit_in};
                     if (cnt == `PSI_DATA_LAST) begin
                        wr_data <= {shift[14:0], bit_in};
                        wr_stb <= 1'b1;
                        state <= S_PRE;
                        cnt <= 6'd0;
                     end
                  end
               end
               default: begin
                  state <= S_PRE;
                  cnt <= 6'd0;
               end
            endcase
         end
      end
   end

endmodule // psi_mgmt_serial

`default_nettype wire

// file: psi_status_irq.v
`timescale 1ns/100ps
`default_nettype none
`include "psi_defs.vh"

// Behaviour
// (R01) Remote fault latches; clears on basic-status read
// (R02) Jabber bit mirrors input, no read clear
// (R03) Bit 4 shows auto-negotiation complete
// (R04) Bit 3 shows loopback enabled
// (R05) Bit 2 shows full duplex
// (R06) Software trusts duplex/speed only with link
// (R07) Bit 1 shows 10 Mb/s speed
// (R08) Bit 0 mirrors link, no read clear
// (R09) Control bits 15:3 ignore writes, read zero
// (R10) Test bit keeps forcing an interrupt
// (R11) Global enable gates individually enabled events
// (R12) Control bit 0 selects shared pin direction
// (R13) Six event source kinds feed interrupts; the code has eight event flags
// (R14) Software sets event enables before expecting interrupts
// (R15) Status and control fields reset to zero
// (R16) Event flags set always, clear on read
// (R17) Bit 7 shows pending; event read clears
// (R18) Pin asserts on test or enabled event
module psi_status_irq #(
   parameter [4:0] PHY_ADDR = 5'h01
) (
   input wire CLK,
   input wire SYS_RST,
   input wire MDC,
   input wire MDIO_I,
   output wire MDIO_O,
   output wire MDIO_OE,
   input wire AN_REMOTE_FAULT,
   input wire JABBER,
   input wire AN_COMPLETE,
   input wire LOOPBACK_ON,
   input wire FULL_DUPLEX,
   input wire SPEED_10,
   input wire LINK_UP,
   input wire ENERGY_DETECT_CHANGE,
   input wire LINK_QUALITY_EVENT,
   input wire FALSE_CARRIER_HALF,
   input wire RX_ERROR_HALF,
   input wire POWERDOWN_OR_IRQ_PIN_I,
   output reg POWERDOWN_OR_IRQ_PIN_O,
   output reg POWERDOWN_OR_IRQ_PIN_OE,
   output reg POWER_DOWN
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   wire rd_stb;             // One-cycle register read strobe.
   wire wr_stb;             // One-cycle register write strobe.
   wire [4:0] reg_addr;     // Register addressed by the current frame.
   wire [15:0] wr_data;     // Write data from the current frame.
   reg [15:0] rd_data;      // Read data for the addressed register.
   reg st_jabber;           // Registered jabber indication.
   reg st_anc;              // Registered auto-negotiation complete.
   reg st_loop;             // Registered loopback state.
   reg st_duplex;           // Registered duplex outcome.
   reg st_speed10;          // Registered speed outcome.
   reg st_link;             // Registered link state.
   reg rfault;              // Sticky remote fault.
   reg icr_test_force;      // Test interrupt force.
   reg icr_event_en;        // Global event interrupt enable.
   reg icr_oe;              // Shared pin configured as interrupt output.
   reg [7:0] evt_flag;      // Event flags, clear on read.
   reg [7:0] evt_en;        // Per-event interrupt enables.
   reg irq_pend;            // Internal interrupt pending.
   reg pd_s1, pd_s2;        // Shared pin synchroniser.
   wire [7:0] new_evt;      // Events occurring this cycle.
   wire clr_evt;            // Event status register is being read.
   wire clr_rfault;         // Basic status register is being read.

   // ----------------------------------------------------------------
   // Management interface
   // ----------------------------------------------------------------
   // The serial slave owns the pin timing; this block only sees one-cycle
   // strobes, so every register below lives wholly in the CLK domain.
   psi_mgmt_serial #(
      .PHY_ADDR(PHY_ADDR)
   ) u_mgmt (
      .clk(CLK),
      .rst(SYS_RST),
      .mdc_pin(MDC),
      .mdio_pin(MDIO_I),
      .mdio_o(MDIO_O),
      .mdio_oe(MDIO_OE),
      .rd_stb(rd_stb),
      .wr_stb(wr_stb),
      .reg_addr(reg_addr),
      .wr_data(wr_data),
      .rd_data(rd_data)
   );

   assign clr_evt = rd_stb && (reg_addr == `PSI_ADDR_EVENT_STATUS);
   assign clr_rfault = rd_stb && (reg_addr == `PSI_ADDR_BASIC_STATUS);

   // Status levels arrive on CLK from the PHY core, so change events are
   // plain comparisons of the input against its registered copy.
   assign new_evt = {LINK_QUALITY_EVENT,      // R13
                     ENERGY_DETECT_CHANGE,
                     LINK_UP ^ st_link,
                     SPEED_10 ^ st_speed10,
                     FULL_DUPLEX ^ st_duplex,
                     AN_COMPLETE & ~st_anc,
                     FALSE_CARRIER_HALF,
                     RX_ERROR_HALF};

   // ----------------------------------------------------------------
   // Summary status capture
   // ----------------------------------------------------------------
   // Copies reset low so the register reads zero straight after reset.
   always @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         st_jabber <= 1'b0;  // R15
         st_anc <= 1'b0;
         st_loop <= 1'b0;
         st_duplex <= 1'b0;
         st_speed10 <= 1'b0;
         st_link <= 1'b0;
         rfault <= 1'b0;
      end else begin
         st_jabber <= JABBER;         // R02
         st_anc <= AN_COMPLETE;       // R03
         st_loop <= LOOPBACK_ON;      // R04
         st_duplex <= FULL_DUPLEX;    // R05
         st_speed10 <= SPEED_10;      // R07
         st_link <= LINK_UP;          // R08
         // A fault reported in the clearing cycle is kept.
         if (AN_REMOTE_FAULT) begin
            rfault <= 1'b1;           // R01
         end else if (clr_rfault) begin
            rfault <= 1'b0;           // R01
         end
      end
   end

   // ----------------------------------------------------------------
   // Control and event registers
   // ----------------------------------------------------------------
   // Writes land the cycle after the strobe. A read of the event register
   // and a new event in the same cycle keep the event, so none is lost.
   always @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         icr_test_force <= 1'b0;   // R15
         icr_event_en <= 1'b0;
         icr_oe <= 1'b0;
         evt_en <= `PSI_EVT_RESET;
         evt_flag <= `PSI_EVT_RESET;
         irq_pend <= 1'b0;
      end else begin
         if (wr_stb && reg_addr == `PSI_ADDR_INT_CTRL) begin
            // Only the three defined bits are stored.
            icr_test_force <= wr_data[`PSI_ICR_TEST_FORCE];    // R09
            icr_event_en <= wr_data[`PSI_ICR_EVENT_EN];
            icr_oe <= wr_data[`PSI_ICR_OE];
         end
         if (wr_stb && reg_addr == `PSI_ADDR_EVENT_STATUS) begin
            evt_en <= wr_data[`PSI_EVT_EN_MSB:0];
         end
         // Flags latch regardless of enables; a new event beats the read clear.
         evt_flag <= (evt_flag & ~{8{clr_evt}}) | new_evt;  // R16
         // Test force re-arms every cycle; events need both enables.
         if (icr_test_force || (icr_event_en && |(new_evt & evt_en))) begin
            irq_pend <= 1'b1;    // R10 R11
         end else if (clr_evt) begin
            irq_pend <= 1'b0;    // R17
         end
      end
   end

   // ----------------------------------------------------------------
   // Shared power-down / interrupt pin
   // ----------------------------------------------------------------
   // The pin is active low in both directions; idle level is high.
   always @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         pd_s1 <= 1'b1;
         pd_s2 <= 1'b1;
         POWERDOWN_OR_IRQ_PIN_O <= 1'b1;
         POWERDOWN_OR_IRQ_PIN_OE <= 1'b0;
         POWER_DOWN <= 1'b0;
      end else begin
         pd_s1 <= POWERDOWN_OR_IRQ_PIN_I;
         pd_s2 <= pd_s1;
         // Direction and level come from the same stored bit and change on
         // one edge, so the pin never shows a level before its direction.
         POWERDOWN_OR_IRQ_PIN_OE <= icr_oe;                  // R12
         POWERDOWN_OR_IRQ_PIN_O <= ~(icr_oe & irq_pend);     // R18
         // Input sense is ignored while the pin is being driven.
         POWER_DOWN <= ~icr_oe & ~pd_s2;                     // R12
      end
   end

   // ----------------------------------------------------------------
   // Read data multiplexer
   // ----------------------------------------------------------------
   // Combinational on purpose: the serial slave captures this word in the
   // strobe cycle, before any clear-on-read side effect takes hold.
   // Unmapped addresses, including basic status, read as zero here.
   always @* begin
      case (reg_addr)
         `PSI_ADDR_SUMMARY: begin
            rd_data = {`PSI_SUM_UPPER, irq_pend, rfault, st_jabber, st_anc,
                       st_loop, st_duplex, st_speed10, st_link};  // R17 R08
         end
         `PSI_ADDR_INT_CTRL: begin
            rd_data = {`PSI_ICR_RESERVED, icr_test_force, icr_event_en, icr_oe};  // R09
         end
         `PSI_ADDR_EVENT_STATUS: begin
            rd_data = {evt_flag, evt_en};
         end
         default: begin
            rd_data = 16'h0000;
         end
      endcase
   end

endmodule // psi_status_irq

`default_nettype wire

// file: psi_mgmt_station.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// Station management controller model
// ------------------------------------------------------------
module psi_mgmt_station (
   input wire logic clk,
   input wire logic mdio,
   output logic mdc,
   output logic drive,
   output logic dout
);
   // The management clock rests low and the data line is released between frames.
   initial begin
      mdc = 1'b0;
      drive = 1'b0;
      dout = 1'b0;
   end
   // One frame; each clock half lasts 5 cycles, because the block needs at least 4.
   // Read data is taken at the rising edge, while the device still holds the bit.
   task automatic xfer(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] rd);
      logic [63:0] f;
      f = {32'hffffffff, 2'b01, op, 5'h01, ra, 2'b10, wd};
      rd = 16'h0000;
      for (int i = 63; i >= 0; i--) begin
         mdc = 1'b0;
         drive = !(op == 2'h2 && i < 18); // Let go at turnaround on reads.
         dout = f[i];
         repeat (5) @(negedge clk);
         mdc = 1'b1;
         if (i < 16) rd = {rd[14:0], mdio};
         repeat (5) @(negedge clk);
      end
      mdc = 1'b0;
      drive = 1'b0;
   endtask
endmodule // psi_mgmt_station
`default_nettype wire

// file: psi_status_irq_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// Pin and interrupt checks at the top-level ports
// ------------------------------------------------------------
module psi_status_irq_asserts (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic MDC,
   input wire logic MDIO_O,
   input wire logic MDIO_OE,
   input wire logic POWERDOWN_OR_IRQ_PIN_I,
   input wire logic POWERDOWN_OR_IRQ_PIN_O,
   input wire logic POWERDOWN_OR_IRQ_PIN_OE,
   input wire logic POWER_DOWN
);
   localparam int QUIET = 8; // Idle cycles after which no frame can still act.
   logic [7:0] mdc_quiet; // Cycles since the management clock was high.
   // Control bits and interrupt clears only change through frames, so a quiet spell freezes them.
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         mdc_quiet <= 8'h00;
      end else if (MDC) begin
         mdc_quiet <= 8'h00;
      end else if (mdc_quiet != 8'hff) begin
         mdc_quiet <= mdc_quiet + 8'h01;
      end
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   sequence s_reset_exit;
      $fell(SYS_RST);
   endsequence
   sequence s_irq_quiet;
      POWERDOWN_OR_IRQ_PIN_OE && !POWERDOWN_OR_IRQ_PIN_O && mdc_quiet >= QUIET;
   endsequence
   reset_pin_a: assert property (s_reset_exit |-> POWERDOWN_OR_IRQ_PIN_O && !POWERDOWN_OR_IRQ_PIN_OE && !POWER_DOWN)
      else $error("shared pin not idle after reset");
   reset_mdio_a: assert property (s_reset_exit |-> MDIO_O && !MDIO_OE)
      else $error("data line driven after reset");
   pin_idle_a: assert property (!POWERDOWN_OR_IRQ_PIN_OE |-> POWERDOWN_OR_IRQ_PIN_O)
      else $error("interrupt asserted while pin is an input");
   pd_input_a: assert property (POWER_DOWN |-> !POWERDOWN_OR_IRQ_PIN_OE || !$past(POWERDOWN_OR_IRQ_PIN_OE))
      else $error("power down while pin is an output");
   pd_cause_a: assert property ($rose(POWER_DOWN) |-> !$past(POWERDOWN_OR_IRQ_PIN_I, 3))
      else $error("power down without low pin");
   pd_release_a: assert property ($fell(POWER_DOWN) |-> $past(POWERDOWN_OR_IRQ_PIN_I, 3) || POWERDOWN_OR_IRQ_PIN_OE)
      else $error("power down dropped while pin low");
   irq_held_a: assert property (s_irq_quiet |=> !POWERDOWN_OR_IRQ_PIN_O || !POWERDOWN_OR_IRQ_PIN_OE)
      else $error("interrupt cleared without a frame");
   oe_by_frame_a: assert property ($changed(POWERDOWN_OR_IRQ_PIN_OE) |-> mdc_quiet < QUIET)
      else $error("pin direction changed without a frame");
endmodule // psi_status_irq_asserts
bind psi_status_irq psi_status_irq_asserts u_asserts (
   .CLK(CLK), .SYS_RST(SYS_RST), .MDC(MDC), .MDIO_O(MDIO_O), .MDIO_OE(MDIO_OE),
   .POWERDOWN_OR_IRQ_PIN_I(POWERDOWN_OR_IRQ_PIN_I), .POWERDOWN_OR_IRQ_PIN_O(POWERDOWN_OR_IRQ_PIN_O),
   .POWERDOWN_OR_IRQ_PIN_OE(POWERDOWN_OR_IRQ_PIN_OE), .POWER_DOWN(POWER_DOWN)
);
`default_nettype wire

// file: phy_status_interrupt_control_test.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// Bench for the status and interrupt control block
// ------------------------------------------------------------
module phy_status_interrupt_control_test;
   logic clk = 1'b0; // System clock.
   logic rst = 1'b1; // Asynchronous reset.
   logic [5:0] st = 6'h00; // Jabber, AN done, loopback, duplex, speed10, link.
   logic rfault = 1'b0; // Remote fault from the partner.
   logic [3:0] ev = 4'h0; // Link quality, energy, false carrier, rx error.
   logic pd_drv = 1'b1; // Level the board drives on the shared pin.
   logic [16:0] seed = 17'h15a84; // Random source.
   logic [5:0] tog [4] = '{6'h01, 6'h02, 6'h04, 6'h10}; // Status bits flipped to raise events.
   int m_fl = 0, m_en = 0, m_ctl = 0, m_irq = 0, m_rf = 0; // Reference model.
   int err_count = 0, checks_done = 0;
   logic [15:0] junk; // Read data of frames that the device must ignore.
   wire mdc, st_drv, st_out, mdio_o, mdio_oe, pin_o, pin_oe, pwr_dn;
   // The data line has a pull-up, so a released line reads high.
   wire mdio = mdio_oe ? mdio_o : (st_drv ? st_out : 1'b1);
   wire pin = pin_oe ? pin_o : pd_drv;
   always #5 clk = ~clk;
   psi_mgmt_station st_m (.clk(clk), .mdio(mdio), .mdc(mdc), .drive(st_drv), .dout(st_out));
   psi_status_irq DUT (
      .CLK(clk), .SYS_RST(rst), .MDC(mdc), .MDIO_I(mdio), .MDIO_O(mdio_o), .MDIO_OE(mdio_oe),
      .AN_REMOTE_FAULT(rfault), .JABBER(st[5]), .AN_COMPLETE(st[4]), .LOOPBACK_ON(st[3]),
      .FULL_DUPLEX(st[2]), .SPEED_10(st[1]), .LINK_UP(st[0]), .ENERGY_DETECT_CHANGE(ev[2]),
      .LINK_QUALITY_EVENT(ev[3]), .FALSE_CARRIER_HALF(ev[1]), .RX_ERROR_HALF(ev[0]),
      .POWERDOWN_OR_IRQ_PIN_I(pin), .POWERDOWN_OR_IRQ_PIN_O(pin_o),
      .POWERDOWN_OR_IRQ_PIN_OE(pin_oe), .POWER_DOWN(pwr_dn)
   );
   // ------------------------------------------------------------
   // Model helpers and transfers
   // ------------------------------------------------------------
   function automatic logic [16:0] lfsr_next(input logic [16:0] s);
      return {s[15:0], s[16] ^ s[13]};
   endfunction
   function automatic logic [15:0] sum();
      return {8'h00, m_irq[0], m_rf[0], st};
   endfunction
   function automatic logic [15:0] evs();
      return {m_fl[7:0], m_en[7:0]};
   endfunction
   task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Pin state is compared as one packed word: level, direction, power down.
   task automatic chk_pin();
      chk_reg({13'h0000, pin_o, pin_oe, pwr_dn},
              {13'h0000, ~(m_ctl[0] & m_irq[0]), m_ctl[0], !m_ctl[0] && !pd_drv});
   endtask
   // Event status reads clear the flags, and the pending interrupt unless test force is set, as a side effect; basic status reads clear remote fault.
   task automatic rd(input logic [4:0] a, input logic [15:0] exp);
      logic [15:0] d;
      st_m.xfer(2'h2, a, 16'h0000, d);
      chk_reg(d, exp);
      if (a == 5'h12) begin
         m_fl = 0;
         m_irq = m_ctl[2];
      end
      if (a == 5'h01) m_rf = 0;
      repeat (12) @(negedge clk);
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] v);
      logic [15:0] d;
      st_m.xfer(2'h1, a, v, d);
      if (a == 5'h11) m_ctl = v[2:0];
      if (a == 5'h12) m_en = v[7:0];
      if (m_ctl[2]) m_irq = 1;
      repeat (12) @(negedge clk);
   endtask
   // New status levels plus one-cycle event pulses; the model sees what changed.
   task automatic apply(input logic [5:0] v, input logic [3:0] e);
      logic [7:0] nf;
      nf = {e[3:2], v[0] ^ st[0], v[1] ^ st[1], v[2] ^ st[2], v[4] & ~st[4], e[1:0]};
      st = v;
      ev = e;
      @(negedge clk);
      ev = 4'h0;
      m_fl = m_fl | nf;
      if (m_ctl[1] && (nf & m_en[7:0]) != 8'h00) m_irq = 1;
      repeat (4) @(negedge clk);
   endtask
   task automatic test_done();
      $display("checks_done=%0d err_count=%0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      repeat (3) @(negedge clk);
      rst = 1'b0;
      repeat (2) @(negedge clk);
      rd(5'h10, 16'h0000);
      rd(5'h11, 16'h0000);
      rd(5'h12, 16'h0000);
      rd(5'h1f, 16'h0000);
      for (int i = 0; i < 2; i++) begin
         pd_drv = i[0];
         repeat (6) @(negedge clk);
         chk_pin();
      end
      for (int i = 0; i < 6; i++) begin
         seed = lfsr_next(seed);
         apply(seed[5:0], 4'h0);
         rd(5'h10, sum());
         rd(5'h10, sum());
      end
      rfault = 1'b1;
      @(negedge clk);
      rfault = 1'b0;
      m_rf = 1;
      rd(5'h10, sum());
      rd(5'h01, 16'h0000);
      rd(5'h10, sum());
      wr(5'h11, 16'hfffa);
      rd(5'h11, 16'h0002);
      // A frame with an undefined opcode must leave the control bits alone.
      st_m.xfer(2'h3, 5'h11, 16'h0007, junk);
      repeat (12) @(negedge clk);
      rd(5'h11, 16'h0002);
      apply(st & 6'h2f, 4'hf);
      rd(5'h10, sum());
      rd(5'h12, evs());
      wr(5'h11, 16'h0003);
      wr(5'h12, 16'h00ff);
      for (int j = 0; j < 8; j++) begin
         if (j < 4) apply(st, 4'(1 << j));
         else apply(st ^ tog[j - 4], 4'h0);
         chk_pin();
         rd(5'h10, sum());
         rd(5'h12, evs());
         chk_pin();
      end
      wr(5'h11, 16'h0001);
      apply(st, 4'h8);
      chk_pin();
      rd(5'h12, evs());
      wr(5'h11, 16'h0005);
      chk_pin();
      rd(5'h12, evs());
      wr(5'h11, 16'h0001);
      rd(5'h10, sum());
      rd(5'h12, evs());
      chk_pin();
      rst = 1'b1;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      m_ctl = 0;
      m_irq = 0;
      m_rf = 0;
      m_en = 0;
      repeat (2) @(negedge clk);
      chk_pin();
      rd(5'h11, 16'h0000);
      rd(5'h10, sum());
      test_done();
   end
   // Cut a hang short; the scenarios need about 35000 cycles.
   initial begin
      repeat (60000) @(posedge clk);
      err_count++;
      test_done();
   end
endmodule // phy_status_interrupt_control_test
`default_nettype wire
